// ### include/spc_pkg.sv
package spc_pkg;
  localparam logic [6:0] ADDR_PIN_CFG = 7'h17;
  localparam logic [6:0] ADDR_DUTY_A  = 7'h18;
  localparam logic [6:0] ADDR_DUTY_B  = 7'h19;
  localparam logic [6:0] ADDR_FREQ    = 7'h1c;
  localparam logic [6:0] ADDR_SCRATCH = 7'h1e;
  localparam logic [7:0] RESET_VALUE  = 8'h00;
  localparam logic [7:0] FREQ_MASK    = 8'h05;
  localparam int         FREQ_A_BIT   = 0;
  localparam int         FREQ_B_BIT   = 2;
  localparam int         PIN1_LSB     = 0;
  localparam int         PIN2_LSB     = 3;
  localparam int         FO_DUTY_LSB  = 6;
  localparam logic [2:0] FN_OFF       = 3'h4;
  localparam logic [2:0] FN_WAKE      = 3'h5;
  localparam logic [2:0] FN_LOW_SIDE  = 3'h6;
  localparam logic [2:0] FN_HIGH_SIDE = 3'h7;
  localparam logic [2:0] HS_ROUTE_A   = 3'h4;
  localparam logic [2:0] HS_ROUTE_B   = 3'h5;
  localparam int         PERIOD_STEPS = 255;
  localparam int         CLK_HZ       = 125000000;
  localparam int         FREQ_LOW_HZ  = 200;
  localparam int         FREQ_HIGH_HZ = 400;
  // Cycles per step, rounded down
  localparam int STEP_LOW  = CLK_HZ / (FREQ_LOW_HZ * PERIOD_STEPS);
  localparam int STEP_HIGH = CLK_HZ / (FREQ_HIGH_HZ * PERIOD_STEPS);
  // Fault output period in pulse-A periods; on periods per code
  localparam int         FO_PERIOD    = 40;
  localparam int         WAKE_FILT_US = 16;
  localparam int         WAKE_CYCLES  = WAKE_FILT_US * (CLK_HZ / 1000000);
endpackage

// ### logic/spc_top.sv
`timescale 1ns/1ps
// How it works
// [R01] Fault output duty 20, 10, 5, 2.5 percent by code, when pin selected
// [R02] Pin function: 0-3 fault out, 4 off, 5 filtered wake, 6 low, 7 high
// [R03] Host pairs filter time with a timer assigned to a high-side switch
// [R04] 8-bit duty: zero off, all ones on, else value over 255
// [R05] Host must not expect tiny duty values to be realized
// [R06] Frequency bit 0 selects 200 or 400 Hz for pulse A
// [R07] Frequency bit 2 selects 200 or 400 Hz for pulse B
// [R08] Frequency bits 7:3 and 1 read zero and ignore writes
// [R09] Pin config and duty bytes clear on power-on and soft reset only
// [R10] Frequency register clears on power-on and soft reset, kept on restart
// [R11] Scratch byte clears only at power-on, survives soft reset
// [R12] Scratch byte host access only in normal state, device never uses it
// [R13] Scratch byte kept through fail-safe and restart
// [R14] Switch code 100 routes pulse A, 101 routes pulse B
// [R15] Each generator counts 255 steps, on while step below duty
module spc_top (
  input  wire logic       CLK,
  input  wire logic       RESET_N,
  input  wire logic       SPI_CLK,
  input  wire logic       SPI_CS_N,
  input  wire logic       SPI_MOSI,
  output logic            SPI_MISO,
  input  wire logic       SOFT_RESET,
  input  wire logic       NORMAL_STATE,
  input  wire logic [2:0] HS_CONFIG,
  input  wire logic       PIN_ONE_IN,
  input  wire logic       PIN_TWO_IN,
  output logic            PULSE_A_OUT,
  output logic            PULSE_B_OUT,
  output logic            HS_DRIVE,
  output logic            PIN_ONE_OUT,
  output logic            PIN_ONE_OE,
  output logic            PIN_TWO_OUT,
  output logic            PIN_TWO_OE,
  output logic            WAKE_EVENT
);
  //////////////////////////////////////////////////////////////////////////
  // Link side: 16-bit frame, address and write bit first, MSB first
  logic [15:0] sh_reg, sh_next;
  logic [4:0]  cnt_reg, cnt_next;
  logic [7:0]  tx_reg, tx_next;
  logic [15:0] word_reg, word_next;
  logic        tog_reg, tog_next;
  logic [7:0]  rd_snap;

  // Frame ends with CS, so the counter is cleared by it asynchronously
  always_comb begin
    sh_next   = {sh_reg[14:0], SPI_MOSI};
    cnt_next  = (cnt_reg == 5'd16) ? cnt_reg : cnt_reg + 5'd1;
    word_next = word_reg;
    tog_next  = tog_reg;
    if (cnt_reg == 5'd15) begin
      word_next = {sh_reg[14:0], SPI_MOSI};
      tog_next  = ~tog_reg;
    end
  end

  always_ff @(posedge SPI_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sh_reg   <= 16'h0000;
      word_reg <= 16'h0000;
      tog_reg  <= 1'b0;
    end else begin
      sh_reg   <= sh_next;
      word_reg <= word_next;
      tog_reg  <= tog_next;
    end
  end

  always_ff @(posedge SPI_CLK or posedge SPI_CS_N) begin
    if (SPI_CS_N) begin
      cnt_reg <= 5'd0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // Read data is a register snapshot; it is quasi-static during a frame
  // Loaded on the falling edge after the write bit, so bit 7 leads edge 9
  always_comb begin
    tx_next = tx_reg;
    if (cnt_reg == 5'd8) begin
      tx_next = rd_snap;
    end else if (cnt_reg > 5'd8) begin
      tx_next = {tx_reg[6:0], 1'b0};
    end
  end

  always_ff @(negedge SPI_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tx_reg <= 8'h00;
    end else begin
      tx_reg <= tx_next;
    end
  end

  assign SPI_MISO = tx_reg[7];

  //////////////////////////////////////////////////////////////////////////
  // Crossing into CLK: toggle sync, word stable for a whole frame
  logic [2:0]  tsync_reg, tsync_next;
  logic        wr_stb;
  logic [6:0]  wr_addr;
  logic [7:0]  wr_data;
  logic        wr_en;

  always_comb begin
    tsync_next = {tsync_reg[1:0], tog_reg};
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tsync_reg <= 3'h0;
    end else begin
      tsync_reg <= tsync_next;
    end
  end

  assign wr_stb  = tsync_reg[2] ^ tsync_reg[1];
  assign wr_addr = word_reg[15:9];
  assign wr_en   = wr_stb & word_reg[8];
  assign wr_data = word_reg[7:0];

  //////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] pin_cfg_reg, pin_cfg_next;
  logic [7:0] duty_a_reg, duty_a_next;
  logic [7:0] duty_b_reg, duty_b_next;
  logic [7:0] freq_reg, freq_next;
  logic [7:0] scratch_reg, scratch_next;
  logic [1:0] soft_sync_reg, soft_sync_next;
  logic [1:0] norm_sync_reg, norm_sync_next;
  logic       soft_rst;

  always_comb begin
    soft_sync_next = {soft_sync_reg[0], SOFT_RESET};
    norm_sync_next = {norm_sync_reg[0], NORMAL_STATE};
  end

  assign soft_rst = soft_sync_reg[1];

  // Restart leaves every register as it was, so it has no input here
  always_comb begin
    pin_cfg_next = pin_cfg_reg;
    duty_a_next  = duty_a_reg;
    duty_b_next  = duty_b_reg;
    freq_next    = freq_reg;
    scratch_next = scratch_reg;
    if (wr_en) begin
      case (wr_addr)
        spc_pkg::ADDR_PIN_CFG: pin_cfg_next = wr_data;
        spc_pkg::ADDR_DUTY_A:  duty_a_next = wr_data;
        spc_pkg::ADDR_DUTY_B:  duty_b_next = wr_data;
        spc_pkg::ADDR_FREQ:    freq_next = wr_data & spc_pkg::FREQ_MASK; // R08
        spc_pkg::ADDR_SCRATCH: begin
          if (norm_sync_reg[1]) begin
            scratch_next = wr_data; // R12
          end
        end
        default: ;
      endcase
    end
    if (soft_rst) begin
      pin_cfg_next = spc_pkg::RESET_VALUE; // R09
      duty_a_next  = spc_pkg::RESET_VALUE; // R09
      duty_b_next  = spc_pkg::RESET_VALUE; // R09
      freq_next    = spc_pkg::RESET_VALUE; // R10
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pin_cfg_reg   <= 8'h00;
      duty_a_reg    <= 8'h00;
      duty_b_reg    <= 8'h00;
      freq_reg      <= 8'h00;
      scratch_reg   <= 8'h00; // R11 R13
      soft_sync_reg <= 2'h0;
      norm_sync_reg <= 2'h0;
    end else begin
      pin_cfg_reg   <= pin_cfg_next;
      duty_a_reg    <= duty_a_next;
      duty_b_reg    <= duty_b_next;
      freq_reg      <= freq_next;
      scratch_reg   <= scratch_next;
      soft_sync_reg <= soft_sync_next;
      norm_sync_reg <= norm_sync_next;
    end
  end

  // Read mux on this frame's address; scratch outside normal reads zero
  always_comb begin
    case (sh_reg[7:1])
      spc_pkg::ADDR_PIN_CFG: rd_snap = pin_cfg_reg;
      spc_pkg::ADDR_DUTY_A:  rd_snap = duty_a_reg;
      spc_pkg::ADDR_DUTY_B:  rd_snap = duty_b_reg;
      spc_pkg::ADDR_FREQ:    rd_snap = freq_reg & spc_pkg::FREQ_MASK; // R08
      spc_pkg::ADDR_SCRATCH: rd_snap = norm_sync_reg[1] ? scratch_reg : 8'h00;
      default:               rd_snap = 8'h00;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Pulse generators
  logic [15:0] pre_a_reg, pre_a_next, pre_b_reg, pre_b_next;
  logic [7:0]  step_a_reg, step_a_next, step_b_reg, step_b_next;
  logic [5:0]  fo_reg, fo_next;
  logic        tick_a, tick_b;
  logic [15:0] lim_a, lim_b;
  logic        out_a, out_b;

  assign lim_a = freq_reg[spc_pkg::FREQ_A_BIT] ? // R06
    16'(spc_pkg::STEP_HIGH - 1) : 16'(spc_pkg::STEP_LOW - 1);
  assign lim_b = freq_reg[spc_pkg::FREQ_B_BIT] ? // R07
    16'(spc_pkg::STEP_HIGH - 1) : 16'(spc_pkg::STEP_LOW - 1);
  assign tick_a = (pre_a_reg >= lim_a);
  assign tick_b = (pre_b_reg >= lim_b);

  always_comb begin
    pre_a_next  = tick_a ? 16'h0000 : pre_a_reg + 16'h0001;
    pre_b_next  = tick_b ? 16'h0000 : pre_b_reg + 16'h0001;
    step_a_next = step_a_reg;
    step_b_next = step_b_reg;
    fo_next     = fo_reg;
    if (tick_a) begin
      step_a_next = (step_a_reg == 8'(spc_pkg::PERIOD_STEPS - 1)) ?
                    8'h00 : step_a_reg + 8'h01; // R15
      if (step_a_reg == 8'(spc_pkg::PERIOD_STEPS - 1)) begin
        fo_next = (fo_reg == 6'(spc_pkg::FO_PERIOD - 1)) ?
                  6'h00 : fo_reg + 6'h01;
      end
    end
    if (tick_b) begin
      step_b_next = (step_b_reg == 8'(spc_pkg::PERIOD_STEPS - 1)) ?
                    8'h00 : step_b_reg + 8'h01; // R15
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pre_a_reg  <= 16'h0000;
      pre_b_reg  <= 16'h0000;
      step_a_reg <= 8'h00;
      step_b_reg <= 8'h00;
      fo_reg     <= 6'h00;
    end else begin
      pre_a_reg  <= pre_a_next;
      pre_b_reg  <= pre_b_next;
      step_a_reg <= step_a_next;
      step_b_reg <= step_b_next;
      fo_reg     <= fo_next;
    end
  end

  // 255 forces on for the whole period
  assign out_a = (duty_a_reg == 8'hff) | (step_a_reg < duty_a_reg); // R04 R15
  assign out_b = (duty_b_reg == 8'hff) | (step_b_reg < duty_b_reg); // R04 R15

  //////////////////////////////////////////////////////////////////////////
  // Fault output: on for 8, 4, 2 or 1 of 40 periods
  logic [5:0] fo_on;
  logic       fo_wave;
  assign fo_on   = 6'h08 >> pin_cfg_reg[spc_pkg::FO_DUTY_LSB +: 2]; // R01
  assign fo_wave = (fo_reg < fo_on); // R01

  //////////////////////////////////////////////////////////////////////////
  // Pin functions and wake filters
  logic [2:0]  fn1, fn2;
  logic [1:0]  p1s_reg, p1s_next, p2s_reg, p2s_next;
  logic [11:0] wf1_reg, wf1_next, wf2_reg, wf2_next;
  logic        wst1_reg, wst1_next, wst2_reg, wst2_next;
  logic        wake_reg, wake_next;

  assign fn1 = pin_cfg_reg[spc_pkg::PIN1_LSB +: 3];
  assign fn2 = pin_cfg_reg[spc_pkg::PIN2_LSB +: 3];

  // Static filter: level must hold for the full time before it is taken
  always_comb begin
    p1s_next  = {p1s_reg[0], PIN_ONE_IN};
    p2s_next  = {p2s_reg[0], PIN_TWO_IN};
    wf1_next  = (p1s_reg[1] != wst1_reg) ? wf1_reg + 12'h001 : 12'h000;
    wf2_next  = (p2s_reg[1] != wst2_reg) ? wf2_reg + 12'h001 : 12'h000;
    wst1_next = wst1_reg;
    wst2_next = wst2_reg;
    wake_next = 1'b0;
    if (wf1_reg == 12'(spc_pkg::WAKE_CYCLES - 1)) begin
      wst1_next = p1s_reg[1];
      wf1_next  = 12'h000;
      wake_next = (fn1 == spc_pkg::FN_WAKE); // R02
    end
    if (wf2_reg == 12'(spc_pkg::WAKE_CYCLES - 1)) begin
      wst2_next = p2s_reg[1];
      wf2_next  = 12'h000;
      wake_next = wake_next | (fn2 == spc_pkg::FN_WAKE); // R02
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      p1s_reg  <= 2'h0;
      p2s_reg  <= 2'h0;
      wf1_reg  <= 12'h000;
      wf2_reg  <= 12'h000;
      wst1_reg <= 1'b0;
      wst2_reg <= 1'b0;
      wake_reg <= 1'b0;
    end else begin
      p1s_reg  <= p1s_next;
      p2s_reg  <= p2s_next;
      wf1_reg  <= wf1_next;
      wf2_reg  <= wf2_next;
      wst1_reg <= wst1_next;
      wst2_reg <= wst2_next;
      wake_reg <= wake_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Output registers
  logic [6:0] pins_reg, pins_next;

  function automatic logic [1:0] pin_drive(input logic [2:0] fn,
                                           input logic       fo);
    logic [1:0] r;
    r = 2'b00;
    case (fn)
      spc_pkg::FN_OFF:       r = 2'b00;
      spc_pkg::FN_WAKE:      r = 2'b00;
      spc_pkg::FN_LOW_SIDE:  r = 2'b10;
      spc_pkg::FN_HIGH_SIDE: r = 2'b11;
      default:               r = {1'b1, fo}; // R02
    endcase
    return r;
  endfunction

  always_comb begin
    pins_next[1:0] = pin_drive(fn1, fo_wave); // R02
    pins_next[3:2] = pin_drive(fn2, fo_wave); // R02
    pins_next[4]   = out_a;
    pins_next[5]   = out_b;
    case (HS_CONFIG)
      spc_pkg::HS_ROUTE_A: pins_next[6] = out_a; // R14
      spc_pkg::HS_ROUTE_B: pins_next[6] = out_b; // R14
      default:             pins_next[6] = 1'b0;
    endcase
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pins_reg <= 7'h00;
    end else begin
      pins_reg <= pins_next;
    end
  end

  assign PIN_ONE_OE  = pins_reg[1];
  assign PIN_ONE_OUT = pins_reg[0];
  assign PIN_TWO_OE  = pins_reg[3];
  assign PIN_TWO_OUT = pins_reg[2];
  assign PULSE_A_OUT = pins_reg[4];
  assign PULSE_B_OUT = pins_reg[5];
  assign HS_DRIVE    = pins_reg[6];
  assign WAKE_EVENT  = wake_reg;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  freq_mask_a: assert property ( // R08
    @(posedge CLK) disable iff (!RESET_N)
    (freq_reg & ~spc_pkg::FREQ_MASK) == 8'h00)
    else $error("Frequency reserved bits set");
  soft_clear_a: assert property ( // R09
    @(posedge CLK) disable iff (!RESET_N)
    soft_rst |=> (duty_a_reg == 8'h00 && pin_cfg_reg == 8'h00 &&
                  duty_b_reg == 8'h00 && freq_reg == 8'h00))
    else $error("Soft reset did not clear");
  scratch_keep_a: assert property ( // R11
    @(posedge CLK) disable iff (!RESET_N)
    !(wr_en && wr_addr == spc_pkg::ADDR_SCRATCH && norm_sync_reg[1])
    |=> $stable(scratch_reg))
    else $error("Scratch changed without write");
  scratch_norm_a: assert property ( // R12
    @(posedge CLK) disable iff (!RESET_N)
    !norm_sync_reg[1] |=> $stable(scratch_reg))
    else $error("Scratch written outside normal");
  duty_off_a: assert property ( // R04
    @(posedge CLK) disable iff (!RESET_N)
    (duty_a_reg == 8'h00) [*2] |-> !PULSE_A_OUT)
    else $error("Zero duty drove output");
  duty_on_a: assert property ( // R04
    @(posedge CLK) disable iff (!RESET_N)
    (duty_b_reg == 8'hff) [*2] |-> PULSE_B_OUT)
    else $error("Full duty not on");
  route_a_a: assert property ( // R14
    @(posedge CLK) disable iff (!RESET_N)
    HS_CONFIG == spc_pkg::HS_ROUTE_A |=> HS_DRIVE == $past(out_a))
    else $error("Switch not routed to pulse A");
  pin_high_a: assert property ( // R02
    @(posedge CLK) disable iff (!RESET_N)
    fn1 == spc_pkg::FN_HIGH_SIDE |=> (PIN_ONE_OE && PIN_ONE_OUT))
    else $error("Pin one high drive missing");
  pin_off_a: assert property ( // R02
    @(posedge CLK) disable iff (!RESET_N)
    fn1 == spc_pkg::FN_OFF |=> !PIN_ONE_OE)
    else $error("Pin one driven while off");
  fault_pin_a: assert property ( // R01
    @(posedge CLK) disable iff (!RESET_N)
    fn2 < spc_pkg::FN_OFF |=>
      (PIN_TWO_OE && PIN_TWO_OUT == $past(fo_wave)))
    else $error("Pin two fault output wrong");
  step_wrap_a: assert property ( // R15
    @(posedge CLK) disable iff (!RESET_N)
    step_a_reg < 8'(spc_pkg::PERIOD_STEPS))
    else $error("Step count out of range");
endmodule

// ### testbench/spc_host_model.sv
`timescale 1ns/1ps
// Host side of the link: mode 0 master, clock idles low between frames
module spc_host_model (
  output logic      spi_clk,
  output logic      spi_cs_n,
  output logic      spi_mosi,
  input  wire logic spi_miso
);
  localparam realtime HALF = 62.5;

  initial begin
    spi_clk  = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end

  ////////////////////////////////////////
  // One whole 16-bit frame, MSB first
  task automatic xfer(input logic [6:0] a, input logic w,
                      input logic [7:0] d, output logic [7:0] q);
    logic [15:0] f;
    f = {a, w, d};
    q = 8'h00;
    spi_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_mosi = f[i];
      #HALF spi_clk = 1'b1;
      if (i < 8) q = {q[6:0], spi_miso};
      #HALF spi_clk = 1'b0;
    end
    #HALF spi_cs_n = 1'b1;
    // Released line must not keep showing the last bit
    spi_mosi = ~spi_mosi;
    #(4 * HALF);
  endtask
endmodule

// ### testbench/spc_top_tb_top.sv
`timescale 1ns/1ps
module spc_top_tb_top;
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       spi_clk;
  logic       spi_cs_n;
  logic       spi_mosi;
  logic       spi_miso;
  logic       soft_reset = 1'b0;
  logic       normal_state = 1'b1;
  logic [2:0] hs_config = 3'h0;
  logic       pin_one_in = 1'b0;
  logic       pin_two_in = 1'b0;
  logic       pulse_a, pulse_b, hs_drive, wake;
  logic       p1_out, p1_oe, p2_out, p2_oe;
  logic [7:0] q;
  logic [6:0] addr [5] = '{spc_pkg::ADDR_PIN_CFG, spc_pkg::ADDR_DUTY_A,
    spc_pkg::ADDR_DUTY_B, spc_pkg::ADDR_FREQ, spc_pkg::ADDR_SCRATCH};
  logic [7:0] pat [5] = '{8'ha5, 8'h5a, 8'hc3, 8'hff, 8'h3c};
  int         miscompares = 0;
  int         tests_run = 0;
  int         cycles = 0;
  int         n;

  always #4 clk = ~clk;

  spc_host_model spc_host_model_inst (
    .spi_clk  (spi_clk),
    .spi_cs_n (spi_cs_n),
    .spi_mosi (spi_mosi),
    .spi_miso (spi_miso)
  );

  spc_top spc_top_inst (
    .CLK          (clk),
    .RESET_N      (reset_n),
    .SPI_CLK      (spi_clk),
    .SPI_CS_N     (spi_cs_n),
    .SPI_MOSI     (spi_mosi),
    .SPI_MISO     (spi_miso),
    .SOFT_RESET   (soft_reset),
    .NORMAL_STATE (normal_state),
    .HS_CONFIG    (hs_config),
    .PIN_ONE_IN   (pin_one_in),
    .PIN_TWO_IN   (pin_two_in),
    .PULSE_A_OUT  (pulse_a),
    .PULSE_B_OUT  (pulse_b),
    .HS_DRIVE     (hs_drive),
    .PIN_ONE_OUT  (p1_out),
    .PIN_ONE_OE   (p1_oe),
    .PIN_TWO_OUT  (p2_out),
    .PIN_TWO_OE   (p2_oe),
    .WAKE_EVENT   (wake)
  );

  ////////////////////////////////////////
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: byte %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: bit %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] dummy;
    spc_host_model_inst.xfer(a, 1'b1, d, dummy);
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    spc_host_model_inst.xfer(a, 1'b0, 8'h00, q);
    chk8(q, exp);
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask

  // Duty of one is never asked for; it would be on for one step of 255
  task automatic pwm_case(input logic [7:0] da, db, input logic [2:0] cfg,
                          input logic ea, eb, eh);
    wr(spc_pkg::ADDR_DUTY_A, da);
    wr(spc_pkg::ADDR_DUTY_B, db);
    cyc(1);
    hs_config = cfg;
    for (int i = 0; i < 4; i++) begin
      cyc(50);
      chk1(pulse_a, ea);
      chk1(pulse_b, eb);
      chk1(hs_drive, eh);
    end
  endtask

  // Fresh power-on, then time three duty steps of each generator
  task automatic freq_case(input logic [7:0] f, input int ea, input int eb);
    int c0;
    int fa;
    int fb;
    cyc(1);
    reset_n = 1'b0;
    cyc(4);
    reset_n = 1'b1;
    c0 = cycles;
    cyc(4);
    wr(spc_pkg::ADDR_FREQ, f);
    wr(spc_pkg::ADDR_DUTY_A, 8'h03);
    wr(spc_pkg::ADDR_DUTY_B, 8'h03);
    fa = 0;
    fb = 0;
    repeat (8000) begin
      cyc(1);
      if (pulse_a !== 1'b1 && fa == 0) fa = cycles - c0;
      if (pulse_b !== 1'b1 && fb == 0) fb = cycles - c0;
    end
    chk1(fa >= ea - 1 && fa <= ea + 1, 1'b1);
    chk1(fb >= eb - 1 && fb <= eb + 1, 1'b1);
    rd(spc_pkg::ADDR_SCRATCH, 8'h00);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      miscompares++;
      end_sim();
    end
  end

  ////////////////////////////////////////
  initial begin
    cyc(4);
    reset_n = 1'b1;
    cyc(4);
    foreach (addr[i]) rd(addr[i], spc_pkg::RESET_VALUE);
    $display("Test reset values done");
    foreach (addr[i]) wr(addr[i], pat[i]);
    for (int i = 0; i < 4; i++) rd(addr[i], i == 3 ?
      (pat[i] & spc_pkg::FREQ_MASK) : pat[i]);
    rd(spc_pkg::ADDR_SCRATCH, 8'h3c);
    wr(7'h1a, 8'hff);
    rd(7'h1a, 8'h00);
    $display("Test write and read done");
    cyc(1);
    normal_state = 1'b0;
    wr(spc_pkg::ADDR_SCRATCH, 8'h77);
    rd(spc_pkg::ADDR_SCRATCH, 8'h00);
    cyc(1);
    normal_state = 1'b1;
    cyc(4);
    rd(spc_pkg::ADDR_SCRATCH, 8'h3c);
    $display("Test scratch gating done");
    cyc(1);
    soft_reset = 1'b1;
    cyc(5);
    soft_reset = 1'b0;
    cyc(5);
    for (int i = 0; i < 4; i++) rd(addr[i], 8'h00);
    rd(spc_pkg::ADDR_SCRATCH, 8'h3c);
    $display("Test soft reset done");
    wr(spc_pkg::ADDR_PIN_CFG, {2'b00, spc_pkg::FN_OFF,
      spc_pkg::FN_HIGH_SIDE});
    cyc(4);
    chk1(p1_oe, 1'b1);
    chk1(p1_out, 1'b1);
    chk1(p2_oe, 1'b0);
    wr(spc_pkg::ADDR_PIN_CFG, {2'b00, spc_pkg::FN_LOW_SIDE,
      spc_pkg::FN_OFF});
    cyc(4);
    chk1(p1_oe, 1'b0);
    chk1(p2_oe, 1'b1);
    chk1(p2_out, 1'b0);
    // Fault output starts its period in the on phase for every code
    wr(spc_pkg::ADDR_PIN_CFG, {2'b11, 3'h0, spc_pkg::FN_OFF});
    cyc(4);
    chk1(p1_oe, 1'b0);
    chk1(p2_oe, 1'b1);
    chk1(p2_out, 1'b1);
    $display("Test pin functions done");
    // Only generator routes are used, no timer codes
    pwm_case(8'hff, 8'h00, spc_pkg::HS_ROUTE_A, 1'b1, 1'b0, 1'b1);
    pwm_case(8'hff, 8'h00, spc_pkg::HS_ROUTE_B, 1'b1, 1'b0, 1'b0);
    wr(spc_pkg::ADDR_FREQ, 8'h05);
    rd(spc_pkg::ADDR_FREQ, 8'h05);
    pwm_case(8'h00, 8'hff, spc_pkg::HS_ROUTE_B, 1'b0, 1'b1, 1'b1);
    pwm_case(8'h00, 8'hff, spc_pkg::HS_ROUTE_A, 1'b0, 1'b1, 1'b0);
    $display("Test pulse outputs done");
    freq_case(8'h01, 3 * spc_pkg::STEP_HIGH + 1,
      3 * spc_pkg::STEP_LOW + 1);
    freq_case(8'h04, 3 * spc_pkg::STEP_LOW + 1,
      3 * spc_pkg::STEP_HIGH + 1);
    $display("Test power-on timing done");
    wr(spc_pkg::ADDR_PIN_CFG, {2'b00, spc_pkg::FN_OFF, spc_pkg::FN_WAKE});
    cyc(10);
    // A short glitch must be filtered out
    pin_one_in = 1'b1;
    cyc(500);
    pin_one_in = 1'b0;
    n = 0;
    repeat (3000) begin
      cyc(1);
      if (wake === 1'b1) n++;
    end
    chk1(n == 0, 1'b1);
    pin_one_in = 1'b1;
    n = 0;
    while (wake !== 1'b1 && n < 3000) begin
      cyc(1);
      n++;
    end
    chk1(n >= spc_pkg::WAKE_CYCLES && n <= spc_pkg::WAKE_CYCLES + 8,
      1'b1);
    $display("Test wake filter done");
    end_sim();
  end
endmodule
